// >>> wdr_watchdog.sv
// Notes on behaviour
// RULE1: debug run bit keeps clock in debug
// RULE2: two-bit field picks counter clock source
// RULE3: fast sources divided by 2048 to 16384
// RULE4: low-speed fixed 1/128, external undivided
// RULE5: software aims for about 256 Hz
// RULE6: absent sources cannot be selected
// RULE7: overflow gives NMI or system reset
// RULE8: NMI flag set by overflow NMI
// RULE9: counter clear also clears NMI flag
// RULE10: NMI handler checks flag for source
// RULE11: clear bit write-one, always reads zero
// RULE12: code 0xA stops, others start
// RULE13: software clears counter when starting
// RULE14: protected writes need key 0x0096
// RULE15: ten-bit counter overflows after 1024 ticks
// RULE16: gated debug clock holds counter and prescaler until a clear
// RULE17: reserved bits read zero, ignore writes
// RULE18: reset leaves watchdog stopped and cleared
//
// The register offsets and the strobed register port were decided locally.
module wdr_watchdog
  import wdr_pkg::*;
#(
  parameter logic [3:0] SRC_PRESENT = 4'hF
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rd_data_o,
  input  wire logic [3:0]        osc_src_i,
  input  wire logic              debug_mode_i,
  output logic                   nmi_o,
  output logic                   sys_reset_req_o,
  output logic                   irq_o
);
  // reset selects source zero, so that source must exist
  if (!SRC_PRESENT[SRC_INT]) begin : g_chk_src
    $error("source zero must be present");
  end

  typedef struct packed {
    logic [3:0]        sync1;
    logic [3:0]        sync2;
    logic [3:0]        sync3;
    logic              run_in_debug;
    logic [1:0]        div_sel;
    wdr_src_t          src_sel;
    logic              act_nmi;
    logic              nmi_flag;
    logic              running;
    logic [CNT_W-1:0]  cnt;
    logic [15:0]       key;
    logic [INT_W-1:0]  int_stat;
    logic [INT_W-1:0]  int_mask;
    logic [DATA_W-1:0] rd_data;
    logic              nmi_pulse;
    logic              rst_pulse;
  } wdr_state_t;

  wdr_state_t s_r;
  wdr_state_t s_nxt;

  wdr_tick_if tk ();

  logic     unlocked;
  logic     wr_clk;
  logic     wr_ctl;
  logic     clear_now;
  logic     count_en;
  logic     ovf;
  wdr_src_t new_src;

  always_comb begin
    unlocked  = (s_r.key == KEY_UNLOCK);
    wr_clk    = wr_i && (addr_i == ADDR_CLK_CFG);
    wr_ctl    = wr_i && (addr_i == ADDR_CTRL);
    new_src   = wdr_src_t'(wr_data_i[CLK_SRC_LSB +: 2]);
    // RULE11: only a one clears
    clear_now = wr_ctl && unlocked && wr_data_i[CTRL_CLR_BIT];
    // RULE1: debug gate with run bit
    count_en  = s_r.running && (!debug_mode_i || s_r.run_in_debug);
    // RULE15: overflow on last count
    ovf       = tk.cnt_tick && count_en && (s_r.cnt == CNT_MAX) && !clear_now;
  end

  always_comb begin
    s_nxt = s_r;
    // only the second and third stages are looked at; the first may be metastable
    s_nxt.sync1 = osc_src_i;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;

    // RULE15: count divided ticks
    if (clear_now) begin
      s_nxt.cnt = '0;
    // RULE16: hold while gated
    end else if (tk.cnt_tick && count_en) begin
      s_nxt.cnt = s_r.cnt + CNT_W'(1);
    end

    // RULE9: clear drops NMI flag
    if (clear_now) begin
      s_nxt.nmi_flag = 1'b0;
    end
    // RULE8: overflow NMI sets flag
    if (ovf && s_r.act_nmi) begin
      s_nxt.nmi_flag = 1'b1;
    end

    // RULE7: action chosen by select bit
    s_nxt.nmi_pulse = ovf && s_r.act_nmi;
    s_nxt.rst_pulse = ovf && !s_r.act_nmi;

    // RULE14: key gates protected writes
    if (wr_clk && unlocked) begin
      s_nxt.run_in_debug   = wr_data_i[CLK_RUN_IN_DEBUG_BIT];
      s_nxt.div_sel = wr_data_i[CLK_DIV_LSB +: 2];
      // RULE6: absent source write ignored
      if (SRC_PRESENT[new_src]) begin
        s_nxt.src_sel = new_src;
      end
    end
    if (wr_ctl && unlocked) begin
      s_nxt.act_nmi = wr_data_i[CTRL_ACT_BIT];
      // RULE12: stop code versus run
      s_nxt.running = (wr_data_i[CTRL_RUN_LSB +: 4] != RUN_STOP_CODE);
    end
    // the key itself is never protected, otherwise it could not be unlocked
    if (wr_i && addr_i == ADDR_KEY) begin
      s_nxt.key = wr_data_i;
    end
    if (wr_i && addr_i == ADDR_INT_MASK) begin
      s_nxt.int_mask = wr_data_i[INT_W-1:0];
    end

    // read clears status; a new event in the same cycle still lands
    if (rd_i && addr_i == ADDR_INT_STAT) begin
      s_nxt.int_stat = '0;
    end
    if (ovf && !s_r.act_nmi) begin
      s_nxt.int_stat[INT_RST_BIT] = 1'b1;
    end
    if (ovf && s_r.act_nmi) begin
      s_nxt.int_stat[INT_NMI_BIT] = 1'b1;
    end

    // RULE17: reserved bits read zero
    s_nxt.rd_data = '0;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CLK_CFG: begin
          s_nxt.rd_data[CLK_RUN_IN_DEBUG_BIT]     = s_r.run_in_debug;
          s_nxt.rd_data[CLK_DIV_LSB +: 2]  = s_r.div_sel;
          s_nxt.rd_data[CLK_SRC_LSB +: 2]  = s_r.src_sel;
        end
        ADDR_CTRL: begin
          s_nxt.rd_data[CTRL_ACT_BIT]      = s_r.act_nmi;
          s_nxt.rd_data[CTRL_NMIF_BIT]     = s_r.nmi_flag;
          // RULE12: run code readback
          s_nxt.rd_data[CTRL_RUN_LSB +: 4] = s_r.running ? RUN_RD_RUN : RUN_RD_IDLE;
        end
        ADDR_KEY:      s_nxt.rd_data = s_r.key;
        ADDR_INT_STAT: s_nxt.rd_data[INT_W-1:0] = s_r.int_stat;
        ADDR_INT_MASK: s_nxt.rd_data[INT_W-1:0] = s_r.int_mask;
        default:       s_nxt.rd_data = '0;
      endcase
    end
  end

  // RULE18: all-zero reset is stopped
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // RULE2: selected source edge
  assign tk.src_tick = s_r.sync2[s_r.src_sel] & ~s_r.sync3[s_r.src_sel];
  assign tk.count_en = count_en;
  assign tk.restart  = clear_now;
  assign tk.src_sel  = s_r.src_sel;
  assign tk.div_sel  = s_r.div_sel;

  wdr_prescaler u_pre (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tk        (tk.pre)
  );

  assign rd_data_o       = s_r.rd_data;
  assign nmi_o           = s_r.nmi_pulse;
  assign sys_reset_req_o = s_r.rst_pulse;
  assign irq_o           = |(s_r.int_stat & s_r.int_mask);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // RULE9: clear drops flag
  a_clear_nmi_flag: assert property ( // RULE9
    clear_now |=> !s_r.nmi_flag && s_r.cnt == '0)
    else $error("counter clear left flag or count");

  // RULE12: stop code stops
  a_stop_code: assert property ( // RULE12
    (wr_ctl && unlocked && wr_data_i[3:0] == RUN_STOP_CODE) |=> !s_r.running)
    else $error("stop code did not stop");

  // RULE12: other codes start
  a_start_code: assert property ( // RULE12
    (wr_ctl && unlocked && wr_data_i[3:0] != RUN_STOP_CODE) |=> s_r.running)
    else $error("run code did not start");

  // RULE12: run code readback
  a_run_readback: assert property ( // RULE12
    (rd_i && addr_i == ADDR_CTRL) |=> rd_data_o[CTRL_RUN_LSB +: 4]
                                      == ($past(s_r.running) ? RUN_RD_RUN : RUN_RD_IDLE))
    else $error("run code readback wrong");

  // RULE12: stopped counter holds
  a_stopped_hold: assert property ( // RULE12
    (!s_r.running && !clear_now) |=> $stable(s_r.cnt))
    else $error("counter moved while stopped");

  // RULE14: locked control ignored
  a_locked_ctrl: assert property ( // RULE14
    (wr_ctl && !unlocked) |=> $stable(s_r.running) && $stable(s_r.act_nmi))
    else $error("locked control write took effect");

  // RULE14: locked clock ignored
  a_locked_clk: assert property ( // RULE14
    (wr_clk && !unlocked) |=> $stable(s_r.src_sel) && $stable(s_r.div_sel)
                              && $stable(s_r.run_in_debug))
    else $error("locked clock write took effect");

  // RULE1: debug run bit lands
  a_run_in_debug_write: assert property ( // RULE1
    (wr_clk && unlocked && wr_data_i[CLK_RUN_IN_DEBUG_BIT]) |=> s_r.run_in_debug)
    else $error("debug run bit not written");

  // RULE8: overflow NMI sets flag
  a_ovf_nmi: assert property ( // RULE8
    (ovf && s_r.act_nmi) |=> nmi_o && s_r.nmi_flag && !sys_reset_req_o ##1 !nmi_o)
    else $error("overflow in NMI mode did not raise one NMI");

  // RULE8: flag only from NMI
  a_flag_source: assert property ( // RULE8
    $rose(s_r.nmi_flag) |-> nmi_o)
    else $error("flag set without NMI");

  // RULE8: flag sticks until clear
  a_nmi_flag_hold: assert property ( // RULE8
    (s_r.nmi_flag && !clear_now) |=> s_r.nmi_flag)
    else $error("flag dropped without counter clear");

  // RULE7: reset mode requests reset
  a_ovf_reset: assert property ( // RULE7
    (ovf && !s_r.act_nmi) |=> sys_reset_req_o && !nmi_o)
    else $error("overflow in reset mode did not request reset");

  // RULE7: one action at a time
  a_nmi_excl: assert property ( // RULE7
    nmi_o |-> !sys_reset_req_o)
    else $error("NMI and reset request together");

  // RULE7: reset event noted
  a_stat_rst: assert property ( // RULE7
    (ovf && !s_r.act_nmi) |=> s_r.int_stat[INT_RST_BIT])
    else $error("reset overflow not noted in status");

  // RULE16: gated debug holds
  a_debug_hold: assert property ( // RULE16
    (debug_mode_i && !s_r.run_in_debug && !clear_now) |=> $stable(s_r.cnt))
    else $error("counter moved in gated debug");

  // RULE6: absent source never held
  a_src_present: assert property ( // RULE6
    SRC_PRESENT[s_r.src_sel])
    else $error("absent source selected");

  // RULE6: absent source write kept
  a_src_keep: assert property ( // RULE6
    (wr_clk && unlocked && !SRC_PRESENT[new_src]) |=> $stable(s_r.src_sel))
    else $error("absent source write changed source");

  // RULE11: clear bit reads zero
  a_read_zero: assert property ( // RULE11
    (rd_i && addr_i == ADDR_CTRL) |=> rd_data_o[CTRL_CLR_BIT] == 1'b0
                                      && rd_data_o[15:10] == '0 && rd_data_o[7:5] == '0)
    else $error("clear bit or reserved bits read nonzero");

  // RULE11: zero in clear bit ignored
  a_clear_write_one: assert property ( // RULE11
    (wr_ctl && unlocked && !wr_data_i[CTRL_CLR_BIT] && !tk.cnt_tick) |=> $stable(s_r.cnt))
    else $error("zero in clear bit moved counter");

  // RULE17: clock reserved bits zero
  a_reserved_clk: assert property ( // RULE17
    (rd_i && addr_i == ADDR_CLK_CFG) |=> rd_data_o[15:9] == '0 && rd_data_o[7:6] == '0
                                         && rd_data_o[3:2] == '0)
    else $error("clock register reserved bits read nonzero");

  // RULE17: no read, zero data
  a_idle_read: assert property ( // RULE17
    !$past(rd_i) |-> rd_data_o == '0)
    else $error("read data outside read cycle");

  // RULE15: counter steps by one
  a_count_step: assert property ( // RULE15
    (tk.cnt_tick && count_en && !clear_now && s_r.cnt != CNT_MAX)
    |=> s_r.cnt == $past(s_r.cnt) + CNT_W'(1))
    else $error("counter did not step by one");

  // RULE15: wrap gives action
  a_wrap_ovf: assert property ( // RULE15
    (tk.cnt_tick && count_en && s_r.cnt == CNT_MAX && !clear_now) |=> s_r.cnt == '0
                                      && (nmi_o || sys_reset_req_o))
    else $error("wrap without overflow action");

  // RULE18: reset state stopped
  a_reset_state: assert property ( // RULE18
    !$past(rst_n_i) |-> !s_r.running && s_r.cnt == '0 && !s_r.nmi_flag && !s_r.act_nmi)
    else $error("state after reset wrong");

  c_nmi_event:   cover property (ovf && s_r.act_nmi);
  c_reset_event: cover property (ovf && !s_r.act_nmi);
  c_debug_hold:  cover property (s_r.running && debug_mode_i && !s_r.run_in_debug);
  c_clear_start: cover property (clear_now && wr_data_i[3:0] != RUN_STOP_CODE);
  c_stop_code:   cover property (wr_ctl && unlocked && wr_data_i[3:0] == RUN_STOP_CODE);
endmodule // wdr_watchdog

// >>> wdr_pkg.sv
package wdr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 10;
  localparam int PRE_W  = 14;
  localparam int INT_W  = 2;

  localparam logic [ADDR_W-1:0] ADDR_CLK_CFG  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_KEY      = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h10;

  localparam int CLK_RUN_IN_DEBUG_BIT = 8;
  localparam int CLK_DIV_LSB   = 4;
  localparam int CLK_SRC_LSB   = 0;
  localparam int CTRL_ACT_BIT  = 9;
  localparam int CTRL_NMIF_BIT = 8;
  localparam int CTRL_CLR_BIT  = 4;
  localparam int CTRL_RUN_LSB  = 0;
  localparam int INT_RST_BIT   = 0;
  localparam int INT_NMI_BIT   = 1;

  localparam logic [15:0]      KEY_UNLOCK    = 16'h0096;
  localparam logic [3:0]       RUN_STOP_CODE = 4'hA;
  localparam logic [3:0]       RUN_RD_IDLE   = 4'hA;
  localparam logic [3:0]       RUN_RD_RUN    = 4'h0;
  localparam logic [CNT_W-1:0] CNT_MAX       = 10'h3FF;
  localparam logic [PRE_W:0]   DIV_BASE      = 15'h0800;
  localparam logic [PRE_W-1:0] DIV_LOW_TERM  = 14'h007F;
  localparam logic [PRE_W-1:0] DIV_EXT_TERM  = 14'h0000;

  typedef enum logic [1:0] {SRC_INT, SRC_LOW, SRC_HIGH, SRC_EXT} wdr_src_t;
endpackage

// >>> wdr_tick_if.sv
interface wdr_tick_if;
  import wdr_pkg::*;
  logic       src_tick;
  logic       count_en;
  logic       restart;
  wdr_src_t   src_sel;
  logic [1:0] div_sel;
  logic       cnt_tick;

  modport ctl (output src_tick, output count_en, output restart, output src_sel,
               output div_sel, input cnt_tick);
  modport pre (input src_tick, input count_en, input restart, input src_sel,
               input div_sel, output cnt_tick);
endinterface

// >>> wdr_prescaler.sv
module wdr_prescaler
  import wdr_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  wdr_tick_if.pre   tk
);
  typedef struct packed {
    logic [PRE_W-1:0] pre_cnt;
    logic             tick;
  } wdr_pre_state_t;

  wdr_pre_state_t s_r;
  wdr_pre_state_t s_nxt;
  logic [PRE_W-1:0] term;

  always_comb begin
    // RULE3: divider from field
    term = PRE_W'((DIV_BASE << tk.div_sel) - (PRE_W+1)'(1));
    unique case (tk.src_sel)
      // RULE4: fixed low-speed ratio
      SRC_LOW:  term = DIV_LOW_TERM;
      SRC_EXT:  term = DIV_EXT_TERM;
      SRC_INT,
      SRC_HIGH: term = PRE_W'((DIV_BASE << tk.div_sel) - (PRE_W+1)'(1));
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    // RULE15: fresh period on clear
    if (tk.restart) begin
      s_nxt.pre_cnt = '0;
    // RULE16: gated clock holds prescaler
    end else if (tk.src_tick && tk.count_en) begin
      if (s_r.pre_cnt >= term) begin
        s_nxt.pre_cnt = '0;
        s_nxt.tick    = 1'b1;
      end else begin
        s_nxt.pre_cnt = s_r.pre_cnt + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tk.cnt_tick = s_r.tick;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_ext_undivided: assert property ( // RULE4
    (tk.src_sel == SRC_EXT && tk.src_tick && tk.count_en && !tk.restart) |=> tk.cnt_tick)
    else $error("external source tick not passed through");
  a_low_ratio: assert property ( // RULE4
    (tk.src_sel == SRC_LOW && s_r.pre_cnt == DIV_LOW_TERM && tk.src_tick && tk.count_en
     && !tk.restart) |=> tk.cnt_tick && s_r.pre_cnt == '0)
    else $error("low-speed source not divided by 128");
  a_div_gate: assert property ( // RULE3
    (tk.src_sel == SRC_INT && s_r.pre_cnt < PRE_W'(DIV_BASE - 1)) |=> !tk.cnt_tick)
    else $error("internal source tick came before the divide terminal");
endmodule // wdr_prescaler

// >>> wdr_far_end.sv
module wdr_far_end (
  input  wire logic       clk_sys_i,
  input  wire logic       nmi_i,
  input  wire logic       sys_reset_req_i,
  output logic      [3:0] osc_o,
  output logic            far_rst_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_r = 2'h0;
  int         nmi_seen = 0;

  initial begin
    osc_o = 4'h0;
    far_rst_n_o = 1'b1;
  end

  // reset controller: three-cycle system reset per request
  always @(posedge clk_sys_i) begin
    if (sys_reset_req_i) hold_r <= 2'h3;
    else if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
    far_rst_n_o <= !(sys_reset_req_i || hold_r > 2'h1);
    if (nmi_i) nmi_seen <= nmi_seen + 1;
  end

  // source pins stand low between bursts, so no stray tick
  // rate scaled up for short runs
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      osc_o <= 4'hF;
      @(posedge clk_sys_i);
      osc_o <= 4'h0;
    end
  endtask
endmodule // wdr_far_end

// >>> wdr_watchdog_tb.sv
module wdr_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wdr_pkg::*;
  logic              clk_sys_i = 1'b0;
  logic              tb_rst_n = 1'b0;
  wire logic         far_rst_n;
  wire logic         rst_n_i = tb_rst_n & far_rst_n;
  logic [ADDR_W-1:0] addr_i = 8'h00;
  logic [DATA_W-1:0] wr_data_i = 16'h0000;
  logic              wr_i = 1'b0;
  logic              rd_i = 1'b0;
  logic              debug_mode_i = 1'b0;
  logic              rd_d = 1'b0;
  wire logic [3:0]   osc_src_i;
  logic [DATA_W-1:0] rd_data_o;
  logic              nmi_o;
  logic              sys_reset_req_o;
  logic              irq_o;
  logic [15:0]       exp_q[$];
  logic [1:0]        ev_q[$];
  logic [31:0]       lfsr = 32'h000179C0;
  logic [15:0]       rnd;
  int                miscompares = 0;
  int                num_checks = 0;

  wdr_watchdog #(.SRC_PRESENT(4'hB)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .osc_src_i(osc_src_i), .debug_mode_i(debug_mode_i), .nmi_o(nmi_o),
    .sys_reset_req_o(sys_reset_req_o), .irq_o(irq_o));
  wdr_far_end i_far (.clk_sys_i(clk_sys_i), .nmi_i(nmi_o), .sys_reset_req_i(sys_reset_req_o),
    .osc_o(osc_src_i), .far_rst_n_o(far_rst_n));

  always #2.5 clk_sys_i = ~clk_sys_i;

  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
  endtask

  // a pulse still queued after the burst counts as missing
  task burst(input int n, input logic [1:0] ev);
    if (ev != 2'b00) ev_q.push_back(ev);
    i_far.ticks(n);
    repeat (8) @(posedge clk_sys_i);
    check("missing pulse", 16'h0000, 16'(ev_q.size()));
  endtask

  task irq_is(input logic e);
    repeat (2) @(posedge clk_sys_i);
    #1 check("irq", {15'h0000, e}, {15'h0000, irq_o});
  endtask

  always @(posedge clk_sys_i) rd_d <= rd_i;

  always @(negedge clk_sys_i) begin
    if (rd_d) check("read data", exp_q.pop_front(), rd_data_o);
    if (nmi_o || sys_reset_req_o)
      check("pulse", {14'h0000, (ev_q.size() > 0) ? ev_q.pop_front() : 2'b00},
            {14'h0000, nmi_o, sys_reset_req_o});
  end

  initial begin
    repeat (40000) @(posedge clk_sys_i);
    miscompares++;
    tally_and_finish;
  end

  initial begin
    repeat (3) @(posedge clk_sys_i);
    tb_rst_n <= 1'b1;
    rd(ADDR_CLK_CFG, 16'h0000);
    rd(ADDR_CTRL, 16'h000A);
    wr(ADDR_CTRL, 16'h0215);
    rd(ADDR_CTRL, 16'h000A);
    wr(ADDR_KEY, KEY_UNLOCK);
    wr(ADDR_CLK_CFG, 16'hFFFF);
    rd(ADDR_CLK_CFG, 16'h0133);
    wr(ADDR_CLK_CFG, 16'h0002);
    rd(ADDR_CLK_CFG, 16'h0003);
    wr(ADDR_INT_MASK, 16'h0001);
    wr(ADDR_CTRL, 16'hFFFF);
    rd(ADDR_CTRL, 16'h0200);
    burst(1024, 2'b10);
    rd(ADDR_CTRL, 16'h0300);
    irq_is(1'b0);
    wr(ADDR_INT_MASK, 16'h0003);
    irq_is(1'b1);
    rd(ADDR_INT_STAT, 16'h0002);
    irq_is(1'b0);
    rd(ADDR_INT_STAT, 16'h0000);
    wr(ADDR_CTRL, 16'h0210);
    rd(ADDR_CTRL, 16'h0200);
    @(posedge clk_sys_i) debug_mode_i <= 1'b1;
    burst(1100, 2'b00);
    @(posedge clk_sys_i) debug_mode_i <= 1'b0;
    burst(1024, 2'b10);
    wr(ADDR_CLK_CFG, 16'h0103);
    wr(ADDR_CTRL, 16'h0210);
    @(posedge clk_sys_i) debug_mode_i <= 1'b1;
    burst(1024, 2'b10);
    @(posedge clk_sys_i) debug_mode_i <= 1'b0;
    wr(ADDR_CTRL, 16'h000A);
    rd(ADDR_CTRL, 16'h010A);
    burst(1100, 2'b00);
    wr(ADDR_CTRL, 16'h0015);
    rd(ADDR_CTRL, 16'h0000);
    burst(1024, 2'b01);
    repeat (4) @(posedge clk_sys_i);
    rd(ADDR_CTRL, 16'h000A);
    rd(ADDR_CLK_CFG, 16'h0000);
    wr(ADDR_KEY, KEY_UNLOCK);
    wr(ADDR_CLK_CFG, 16'h0002);
    rd(ADDR_CLK_CFG, 16'h0000);
    repeat (4) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      rnd = lfsr[15:0] | 16'h8000;
      wr(ADDR_KEY, rnd);
      rd(ADDR_KEY, rnd);
      wr(ADDR_CTRL, 16'h0215);
      rd(ADDR_CTRL, 16'h000A);
      wr(ADDR_CLK_CFG, rnd);
      rd(ADDR_CLK_CFG, 16'h0000);
      wr(8'h14, rnd);
      rd(8'h14, 16'h0000);
    end
    check("nmi count", 16'h0003, 16'(i_far.nmi_seen));
    tally_and_finish;
  end
endmodule // wdr_watchdog_tb
